/* File: logic/tdcu_regs.svh */
`ifndef TDCU_REGS_SVH
`define TDCU_REGS_SVH
// How it works
// - the select index picks which trigger's three data registers the data addresses reach
// - select writes naming a missing trigger are dropped; only legal indices stay
// - first data register: read-only 4-bit type in [31:28], trigger data in [27:0]
// - type codes: 0 none, 1 reserved, 2 address/data match, 3 and up reserved
// - the second and third data registers are full-width read/write windows onto the selected trigger; the first is legalized
// - debug control/status, saved pc and scratch are reachable only in debug mode
// - select is reachable in debug and machine mode; the three data registers too, except from machine mode for a debug-owned trigger
// - the ownership bit gives a trigger to debug mode; only debug code may use it
// - machine-mode access to data registers of a debug-owned trigger is an illegal instruction
// - entering debug mode copies the current pc into the saved debug pc
// - leaving debug mode resumes execution at the saved debug pc
// - a debug-owned trigger reads type zero from machine mode
// - an implemented breakpoint trigger reports type two
// - two breakpoint triggers per hart, shared between debug and machine mode

// ---------------------------------------------------------------
// register addresses in the control-register space
// ---------------------------------------------------------------
`define TDCU_ADDR_SELECT 12'h7A0
`define TDCU_ADDR_DATA_FIRST 12'h7A1
`define TDCU_ADDR_DATA_SECOND 12'h7A2
`define TDCU_ADDR_DATA_THIRD 12'h7A3
`define TDCU_ADDR_DBG_CTRL 12'h7B0
`define TDCU_ADDR_DBG_PC 12'h7B1
`define TDCU_ADDR_DBG_SCRATCH 12'h7B2

// ---------------------------------------------------------------
// first data register field positions
// ---------------------------------------------------------------
`define TDCU_TYPE_MSB 31
`define TDCU_TYPE_LSB 28
`define TDCU_DMODE_BIT 27
`define TDCU_MASKMAX_MSB 26
`define TDCU_MASKMAX_LSB 21
`define TDCU_SELECT_BIT 19
`define TDCU_TIMING_BIT 18
`define TDCU_ACTION_MSB 17
`define TDCU_ACTION_LSB 12
`define TDCU_CHAIN_BIT 11
`define TDCU_MATCH_MSB 10
`define TDCU_MATCH_LSB 7
`define TDCU_PRIV_M_BIT 6
`define TDCU_PRIV_S_BIT 4
`define TDCU_PRIV_U_BIT 3
`define TDCU_EXEC_BIT 2
`define TDCU_STORE_BIT 1
`define TDCU_LOAD_BIT 0

// ---------------------------------------------------------------
// values and reset values
// ---------------------------------------------------------------
`define TDCU_TYPE_NONE 4'h0
`define TDCU_TYPE_MATCH 4'h2
`define TDCU_MASKMAX_VAL 6'h04
`define TDCU_ACTION_MAX 6'h01
`define TDCU_NUM_TRIG 2
`define TDCU_DBG_CTRL_RST 32'h00000000
`define TDCU_DBG_PC_RST 32'h00000000
`define TDCU_DBG_SCRATCH_RST 32'h00000000
`define TDCU_TRIG_DATA_RST 32'h00000000
`endif

/* File: logic/tdcu_pkg.sv */
package tdcu_pkg;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic {
    TDCU_RUN,
    TDCU_HALTED
  } tdcu_mode_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } tdcu_req_s;

  typedef struct packed {
    logic ack;
    logic hit;
    logic illegal;
    logic [31:0] rdata;
  } tdcu_rsp_s;

  typedef struct packed {
    logic dmode;
    logic [5:0] action;
    logic chain;
    logic [3:0] match;
    logic priv_m;
    logic priv_s;
    logic priv_u;
    logic exec;
    logic store;
    logic load;
  } tdcu_ctrl_s;

endpackage : tdcu_pkg

/* File: logic/tdcu_trigger.sv */
`timescale 1ns/10ps
`include "tdcu_regs.svh"

module tdcu_trigger (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic wr_ctrl_i,
  input wire logic wr_addr_i,
  input wire logic wr_third_i,
  input wire logic debug_mode_i,
  input wire logic [31:0] wdata_i,
  output tdcu_pkg::tdcu_ctrl_s ctrl_o,
  output logic [31:0] ctrl_word_o,
  output logic [31:0] addr_o,
  output logic [31:0] third_o
);

  // ---------------------------------------------------------------
  // legalized control value
  // ---------------------------------------------------------------
  tdcu_pkg::tdcu_ctrl_s next_ctrl;
  wire [5:0] wr_action = wdata_i[`TDCU_ACTION_MSB:`TDCU_ACTION_LSB];
  wire action_ok = (wr_action <= `TDCU_ACTION_MAX);
  // only debug code may hand the trigger to debug mode or take it back
  wire next_dmode = debug_mode_i ? wdata_i[`TDCU_DMODE_BIT] : ctrl_o.dmode;

  assign next_ctrl = '{
    dmode: next_dmode,
    action: action_ok ? wr_action : ctrl_o.action,
    chain: wdata_i[`TDCU_CHAIN_BIT],
    match: wdata_i[`TDCU_MATCH_MSB:`TDCU_MATCH_LSB],
    priv_m: wdata_i[`TDCU_PRIV_M_BIT],
    priv_s: wdata_i[`TDCU_PRIV_S_BIT],
    priv_u: wdata_i[`TDCU_PRIV_U_BIT],
    exec: wdata_i[`TDCU_EXEC_BIT],
    store: wdata_i[`TDCU_STORE_BIT],
    load: wdata_i[`TDCU_LOAD_BIT]
  };

  // reserved, timing and select bits read zero; type and maskmax are fixed
  assign ctrl_word_o = {`TDCU_TYPE_MATCH, ctrl_o.dmode, `TDCU_MASKMAX_VAL, 1'b0, 1'b0, 1'b0,
                        ctrl_o.action, ctrl_o.chain, ctrl_o.match, ctrl_o.priv_m, 1'b0,
                        ctrl_o.priv_s, ctrl_o.priv_u, ctrl_o.exec, ctrl_o.store,
                        ctrl_o.load};

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_o <= '0;
    end else if (wr_ctrl_i) begin
      ctrl_o <= next_ctrl;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      addr_o <= `TDCU_TRIG_DATA_RST;
    end else if (wr_addr_i) begin
      addr_o <= wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      third_o <= `TDCU_TRIG_DATA_RST;
    end else if (wr_third_i) begin
      third_o <= wdata_i;
    end
  end

endmodule : tdcu_trigger

/* File: logic/tdcu_top.sv */
`timescale 1ns/10ps
`include "tdcu_regs.svh"

module tdcu_top #(
  parameter int NUM_TRIG = `TDCU_NUM_TRIG
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input tdcu_pkg::tdcu_req_s req_i,
  input wire logic debug_enter_i,
  input wire logic debug_exit_i,
  input wire logic [31:0] pc_i,
  output tdcu_pkg::tdcu_rsp_s rsp_o,
  output logic debug_mode_o,
  output logic resume_o,
  output logic [31:0] resume_pc_o,
  output logic [31:0] debug_ctrl_o,
  output logic [NUM_TRIG*32-1:0] trig_ctrl_o,
  output logic [NUM_TRIG*32-1:0] trig_addr_o
);

  localparam int IDXW = (NUM_TRIG > 1) ? $clog2(NUM_TRIG) : 1;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tdcu_pkg::tdcu_mode_e mode;
  tdcu_pkg::tdcu_mode_e next_mode;
  logic [IDXW-1:0] select_index;
  logic [31:0] debug_pc;
  logic [31:0] debug_scratch;
  tdcu_pkg::tdcu_rsp_s next_rsp;

  // ---------------------------------------------------------------
  // per-trigger bank
  // ---------------------------------------------------------------
  logic [31:0] bank_ctrl_word [NUM_TRIG];
  logic [31:0] bank_addr [NUM_TRIG];
  logic [31:0] bank_third [NUM_TRIG];
  logic [NUM_TRIG-1:0] bank_dmode;
  logic [NUM_TRIG-1:0] bank_wr_ctrl;
  logic [NUM_TRIG-1:0] bank_wr_addr;
  logic [NUM_TRIG-1:0] bank_wr_third;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire in_debug = (mode == tdcu_pkg::TDCU_HALTED);
  wire [11:0] addr = req_i.addr;
  wire hit_select = (addr == `TDCU_ADDR_SELECT);
  wire hit_first = (addr == `TDCU_ADDR_DATA_FIRST);
  wire hit_second = (addr == `TDCU_ADDR_DATA_SECOND);
  wire hit_third = (addr == `TDCU_ADDR_DATA_THIRD);
  wire hit_dbg_ctrl = (addr == `TDCU_ADDR_DBG_CTRL);
  wire hit_dbg_pc = (addr == `TDCU_ADDR_DBG_PC);
  wire hit_dbg_scratch = (addr == `TDCU_ADDR_DBG_SCRATCH);
  wire hit_data = hit_first | hit_second | hit_third;
  wire hit_dbg_only = hit_dbg_ctrl | hit_dbg_pc | hit_dbg_scratch;
  wire hit_any = hit_select | hit_data | hit_dbg_only;

  // ---------------------------------------------------------------
  // access checks
  // ---------------------------------------------------------------
  wire sel_dmode = bank_dmode[select_index];
  // machine mode loses the trigger once debug mode owns it
  wire sel_hidden = sel_dmode & ~in_debug;
  wire bad_dbg = hit_dbg_only & ~in_debug;
  wire bad_data = hit_data & sel_hidden;
  wire illegal = req_i.valid & (bad_dbg | bad_data);
  wire do_write = req_i.valid & req_i.write & hit_any & ~(bad_dbg | bad_data);

  // ---------------------------------------------------------------
  // select index legalization
  // ---------------------------------------------------------------
  wire sel_legal = (req_i.wdata < 32'(NUM_TRIG));
  wire wr_select = do_write & hit_select & sel_legal;
  wire [IDXW-1:0] wr_index = req_i.wdata[IDXW-1:0];

  // ---------------------------------------------------------------
  // bank instances and their write strobes
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_TRIG; g++) begin : g_trig
      tdcu_pkg::tdcu_ctrl_s ctrl;
      wire picked = (select_index == IDXW'(g));
      assign bank_wr_ctrl[g] = do_write & hit_first & picked;
      assign bank_wr_addr[g] = do_write & hit_second & picked;
      assign bank_wr_third[g] = do_write & hit_third & picked;
      assign bank_dmode[g] = ctrl.dmode;
      assign trig_ctrl_o[g*32 +: 32] = bank_ctrl_word[g];
      assign trig_addr_o[g*32 +: 32] = bank_addr[g];
      tdcu_trigger u_trig (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .wr_ctrl_i(bank_wr_ctrl[g]),
        .wr_addr_i(bank_wr_addr[g]),
        .wr_third_i(bank_wr_third[g]),
        .debug_mode_i(in_debug),
        .wdata_i(req_i.wdata),
        .ctrl_o(ctrl),
        .ctrl_word_o(bank_ctrl_word[g]),
        .addr_o(bank_addr[g]),
        .third_o(bank_third[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  wire [31:0] sel_ctrl_word = bank_ctrl_word[select_index];
  wire [31:0] sel_addr = bank_addr[select_index];
  wire [31:0] sel_third = bank_third[select_index];
  // a hidden trigger reads type zero with all data zero
  wire [31:0] first_view = sel_hidden ? {`TDCU_TYPE_NONE, 28'h0000000} : sel_ctrl_word;
  wire [31:0] select_view = {{(32 - IDXW){1'b0}}, select_index};

  wire [31:0] rd_value =
    hit_select ? select_view :
    hit_first ? first_view :
    hit_second ? sel_addr :
    hit_third ? sel_third :
    hit_dbg_ctrl ? debug_ctrl_o :
    hit_dbg_pc ? debug_pc :
    hit_dbg_scratch ? debug_scratch :
    32'h00000000;

  // faulting accesses return zero so nothing leaks to machine mode
  assign next_rsp = '{
    ack: req_i.valid,
    hit: req_i.valid & hit_any,
    illegal: illegal,
    rdata: (req_i.valid & ~illegal) ? rd_value : 32'h00000000
  };

  // ---------------------------------------------------------------
  // debug mode sequencing
  // ---------------------------------------------------------------
  wire enter_now = (mode == tdcu_pkg::TDCU_RUN) & debug_enter_i;
  wire leave_now = (mode == tdcu_pkg::TDCU_HALTED) & debug_exit_i;

  always_comb begin
    next_mode = mode;
    case (mode)
      tdcu_pkg::TDCU_RUN: begin
        if (debug_enter_i) begin
          next_mode = tdcu_pkg::TDCU_HALTED;
        end
      end
      tdcu_pkg::TDCU_HALTED: begin
        if (debug_exit_i) begin
          next_mode = tdcu_pkg::TDCU_RUN;
        end
      end
      default: begin
        next_mode = tdcu_pkg::TDCU_RUN;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mode <= tdcu_pkg::TDCU_RUN;
      debug_mode_o <= 1'b0;
    end else begin
      mode <= next_mode;
      debug_mode_o <= (next_mode == tdcu_pkg::TDCU_HALTED);
    end
  end

  // ---------------------------------------------------------------
  // resume request toward the pipeline
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      resume_o <= 1'b0;
      resume_pc_o <= `TDCU_DBG_PC_RST;
    end else begin
      resume_o <= leave_now;
      if (leave_now) begin
        resume_pc_o <= debug_pc;
      end
    end
  end

  // ---------------------------------------------------------------
  // saved pc
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      debug_pc <= `TDCU_DBG_PC_RST;
    end else if (enter_now) begin
      debug_pc <= pc_i;
    end else if (do_write & hit_dbg_pc) begin
      debug_pc <= req_i.wdata;
    end
  end

  // ---------------------------------------------------------------
  // debug control/status and scratch
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      debug_ctrl_o <= `TDCU_DBG_CTRL_RST;
    end else if (do_write & hit_dbg_ctrl) begin
      debug_ctrl_o <= req_i.wdata;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      debug_scratch <= `TDCU_DBG_SCRATCH_RST;
    end else if (do_write & hit_dbg_scratch) begin
      debug_scratch <= req_i.wdata;
    end
  end

  // ---------------------------------------------------------------
  // select index
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      select_index <= '0;
    end else if (wr_select) begin
      select_index <= wr_index;
    end
  end

  // ---------------------------------------------------------------
  // registered answer
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o <= next_rsp;
    end
  end

endmodule : tdcu_top

/* File: verification/tdcu_monitor.sv */
`timescale 1ns/10ps
module tdcu_monitor #(
  parameter int NUM_TRIG = 2
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input tdcu_pkg::tdcu_req_s req_i,
  input wire logic debug_enter_i,
  input wire logic debug_exit_i,
  input wire logic [31:0] pc_i,
  input tdcu_pkg::tdcu_rsp_s rsp_o,
  input wire logic debug_mode_o,
  input wire logic resume_o,
  input wire logic [31:0] resume_pc_o,
  input wire logic [31:0] debug_ctrl_o,
  input wire logic [NUM_TRIG*32-1:0] trig_ctrl_o,
  input wire logic [NUM_TRIG*32-1:0] trig_addr_o
);
  // ---------------------------------------------------------------
  // decode of the request and of trigger ownership
  // ---------------------------------------------------------------
  wire dbg_reg = req_i.valid && req_i.addr inside {12'h7B0, 12'h7B1, 12'h7B2};
  wire dat_reg = req_i.valid && req_i.addr inside {12'h7A1, 12'h7A2, 12'h7A3};
  wire own_all = trig_ctrl_o[27] && trig_ctrl_o[NUM_TRIG*32-5];
  wire own_none = !trig_ctrl_o[27] && !trig_ctrl_o[NUM_TRIG*32-5];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_follows_req: assert property (req_i.valid |=> rsp_o.ack)
    else $error("request not answered");
  a_no_stray_ack: assert property (!req_i.valid |=> !rsp_o.ack && !rsp_o.illegal)
    else $error("answer without request");
  a_dbg_reg_fault: assert property (dbg_reg && !debug_mode_o |=>
    rsp_o.illegal && rsp_o.rdata == 32'h0) else $error("debug register open in run mode");
  a_dbg_reg_open: assert property (dbg_reg && debug_mode_o |=> rsp_o.hit && !rsp_o.illegal)
    else $error("debug register refused in debug mode");
  a_owned_fault: assert property (dat_reg && !debug_mode_o && own_all |=>
    rsp_o.illegal && rsp_o.rdata == 32'h0) else $error("owned trigger visible");
  a_shared_open: assert property (dat_reg && own_none |=> rsp_o.hit && !rsp_o.illegal)
    else $error("shared trigger refused");
  a_type_fixed: assert property (trig_ctrl_o[31:28] == 4'h2 &&
    trig_ctrl_o[NUM_TRIG*32-1 -: 4] == 4'h2) else $error("type code not two");
  a_type_read: assert property (req_i.valid && req_i.addr == 12'h7A1 |=>
    rsp_o.illegal || rsp_o.rdata[31:28] == 4'h2) else $error("visible trigger type not two");
  a_resume_pc_hold: assert property (!resume_o |-> $stable(resume_pc_o))
    else $error("resume pc moved without exit");
  a_enter_mode: assert property (debug_enter_i && !debug_mode_o |=> debug_mode_o)
    else $error("debug entry not taken");
  a_exit_resume: assert property (debug_exit_i && debug_mode_o |=>
    resume_o && !debug_mode_o ##1 !resume_o) else $error("exit without single resume");
  c_exit: cover property (debug_exit_i && debug_mode_o);
  c_fault: cover property (dat_reg && own_all && !debug_mode_o);
  c_back_to_back: cover property (req_i.valid ##1 req_i.valid);
endmodule : tdcu_monitor

bind tdcu_top tdcu_monitor #(.NUM_TRIG(NUM_TRIG)) i_tdcu_monitor (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .req_i(req_i), .debug_enter_i(debug_enter_i),
  .debug_exit_i(debug_exit_i), .pc_i(pc_i), .rsp_o(rsp_o), .debug_mode_o(debug_mode_o),
  .resume_o(resume_o), .resume_pc_o(resume_pc_o), .debug_ctrl_o(debug_ctrl_o),
  .trig_ctrl_o(trig_ctrl_o), .trig_addr_o(trig_addr_o));

/* File: verification/tdcu_hart_model.sv */
`timescale 1ns/10ps
module tdcu_hart_model (
  input wire logic clock_i,
  input tdcu_pkg::tdcu_rsp_s rsp_i,
  output tdcu_pkg::tdcu_req_s req_o
);
  initial req_o = '0;
  // drive after a falling edge, hold over the taking edge, collect the answer a cycle on
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
      output tdcu_pkg::tdcu_rsp_s r);
    req_o.valid = 1'h1;
    req_o.write = w;
    req_o.addr = a;
    req_o.wdata = d;
    @(negedge clock_i);
    r = rsp_i;
  endtask : access
  // released address and write data are scrambled so a stale value never looks like a request
  task automatic idle;
    req_o.valid = 1'h0;
    req_o.addr = ~req_o.addr;
    req_o.wdata = ~req_o.wdata;
  endtask : idle
endmodule : tdcu_hart_model

/* File: verification/tb.sv */
`timescale 1ns/10ps
`include "tdcu_regs.svh"
module tb;
  localparam int NT = 2;
  logic clock_i;
  logic rst_n_i = 1'h0;
  logic enter = 1'h0;
  logic leave = 1'h0;
  logic [31:0] pc = 32'h0;
  tdcu_pkg::tdcu_req_s req;
  tdcu_pkg::tdcu_rsp_s rsp;
  logic dbg_mode;
  logic resume;
  logic [31:0] resume_pc;
  logic [31:0] dctrl;
  logic [NT*32-1:0] tctrl;
  logic [NT*32-1:0] taddr;
  int err_count = 0;
  int checked = 0;
  int m_sel = 0;
  logic m_dbg = 1'h0;
  logic [31:0] m_dctrl = 32'h0;
  logic [31:0] m_dpc = 32'h0;
  logic [31:0] m_scr = 32'h0;
  logic [31:0] m_rpc = 32'h0;
  logic [31:0] m_ctrl[NT] = '{default: {`TDCU_TYPE_MATCH, 1'h0, `TDCU_MASKMAX_VAL, 21'h0}};
  logic [31:0] m_addr[NT] = '{default: 32'h0};
  logic [31:0] m_third[NT] = '{default: 32'h0};

  tdcu_top #(.NUM_TRIG(NT)) i_tdcu_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req),
    .debug_enter_i(enter), .debug_exit_i(leave), .pc_i(pc), .rsp_o(rsp),
    .debug_mode_o(dbg_mode), .resume_o(resume), .resume_pc_o(resume_pc),
    .debug_ctrl_o(dctrl), .trig_ctrl_o(tctrl), .trig_addr_o(taddr));
  tdcu_hart_model i_hart (.clock_i(clock_i), .rsp_i(rsp), .req_o(req));

  initial begin
    clock_i = 1'h0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // comparison and reference model
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic st;
    for (int g = 0; g < NT; g++) begin
      chk("trig_ctrl", m_ctrl[g], tctrl[g*32 +: 32]);
      chk("trig_addr", m_addr[g], taddr[g*32 +: 32]);
    end
    chk("debug_ctrl", m_dctrl, dctrl);
  endtask : st
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    tdcu_pkg::tdcu_rsp_s r;
    logic ill;
    logic hm;
    logic [31:0] rd;
    logic [5:0] act;
    int s;
    s = m_sel;
    hm = a inside {12'h7A0, 12'h7A1, 12'h7A2, 12'h7A3, 12'h7B0, 12'h7B1, 12'h7B2};
    ill = !m_dbg && (a inside {12'h7B0, 12'h7B1, 12'h7B2} ||
      (a inside {12'h7A1, 12'h7A2, 12'h7A3} && m_ctrl[s][27]));
    case (a)
      12'h7A0: rd = 32'(m_sel);
      12'h7A1: rd = m_ctrl[s];
      12'h7A2: rd = m_addr[s];
      12'h7A3: rd = m_third[s];
      12'h7B0: rd = m_dctrl;
      12'h7B1: rd = m_dpc;
      12'h7B2: rd = m_scr;
      default: rd = 32'h0;
    endcase
    i_hart.access(w, a, d, r);
    chk("ack", 32'h1, 32'(r.ack));
    chk("hit", 32'(hm), 32'(r.hit));
    chk("illegal", 32'(ill), 32'(r.illegal));
    chk("rdata", ill ? 32'h0 : rd, r.rdata);
    act = (d[17:12] > 6'h01) ? m_ctrl[s][17:12] : d[17:12];
    if (w && !ill) begin
      case (a)
        12'h7A0: if (d < NT) m_sel = int'(d);
        12'h7A1: m_ctrl[s] = {`TDCU_TYPE_MATCH, m_dbg ? d[27] : m_ctrl[s][27],
          `TDCU_MASKMAX_VAL, 3'h0, act, d[11:6], 1'h0, d[4:0]};
        12'h7A2: m_addr[s] = d;
        12'h7A3: m_third[s] = d;
        12'h7B0: m_dctrl = d;
        12'h7B1: m_dpc = d;
        12'h7B2: m_scr = d;
        default: ;
      endcase
    end
    st();
  endtask : acc
  task automatic ev(input logic en, input logic ex);
    logic rs;
    i_hart.idle();
    @(negedge clock_i);
    enter = en;
    leave = ex;
    pc = $urandom;
    rs = ex && m_dbg;
    if (en && !m_dbg) begin
      m_dbg = 1'h1;
      m_dpc = pc;
    end else if (rs) begin
      m_dbg = 1'h0;
      m_rpc = m_dpc;
    end
    @(negedge clock_i);
    enter = 1'h0;
    leave = 1'h0;
    chk("debug_mode", 32'(m_dbg), 32'(dbg_mode));
    chk("resume", 32'(rs), 32'(resume));
    chk("resume_pc", m_rpc, resume_pc);
  endtask : ev
  task automatic report_and_stop;
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h8A6F));
    repeat (8) @(negedge clock_i);
    rst_n_i = 1'h1;
    @(negedge clock_i);
    st();
    acc(1'h0, 12'h7A1, 32'h0);
    for (int i = 0; i < 3; i++) begin
      acc(1'h1, 12'h7B0 + 12'(i), $urandom);
      acc(1'h0, 12'h7B0 + 12'(i), 32'h0);
    end
    acc(1'h0, 12'h7A4, 32'h0);
    acc(1'h1, 12'h7A0, 32'h1);
    acc(1'h1, 12'h7A0, 32'h2);
    acc(1'h1, 12'h7A0, 32'hFFFFFFFF);
    acc(1'h0, 12'h7A0, 32'h0);
    for (int g = 0; g < NT; g++) begin
      acc(1'h1, 12'h7A0, 32'(g));
      for (int i = 1; i < 4; i++) begin
        acc(1'h1, 12'h7A0 + 12'(i), $urandom);
        acc(1'h0, 12'h7A0 + 12'(i), 32'h0);
      end
    end
    ev(1'h0, 1'h1);
    ev(1'h1, 1'h0);
    ev(1'h1, 1'h0);
    for (int i = 0; i < 3; i++) begin
      acc(1'h0, 12'h7B0 + 12'(i), 32'h0);
      acc(1'h1, 12'h7B0 + 12'(i), $urandom);
    end
    for (int g = 0; g < NT; g++) begin
      acc(1'h1, 12'h7A0, 32'(g));
      acc(1'h1, 12'h7A1, $urandom | 32'h08000000);
      acc(1'h0, 12'h7A2, 32'h0);
    end
    ev(1'h0, 1'h1);
    for (int i = 1; i < 4; i++) begin
      acc(1'h0, 12'h7A0 + 12'(i), 32'h0);
      acc(1'h1, 12'h7A0 + 12'(i), $urandom);
    end
    acc(1'h1, 12'h7A0, 32'h0);
    ev(1'h1, 1'h0);
    acc(1'h1, 12'h7A1, 32'h00001000);
    acc(1'h1, 12'h7B1, $urandom);
    ev(1'h0, 1'h1);
    acc(1'h0, 12'h7A1, 32'h0);
    acc(1'h1, 12'h7A2, $urandom);
    acc(1'h1, 12'h7A0, 32'h1);
    acc(1'h0, 12'h7A1, 32'h0);
    report_and_stop();
  end
endmodule : tb
